// *** logic/pmc_pkg.sv ***
// Constants, encodings and types of the power mode controller
package pmc_pkg;
  // Peripheral slots of the gate vectors
  localparam int NUM_PERIPH     = 12;
  localparam int PI_USB0        = 0;
  localparam int PI_USB1        = 1;
  localparam int PI_MIC         = 2;
  localparam int PI_SPI         = 3;
  localparam int PI_I2C         = 4;
  localparam int PI_USART       = 5;
  localparam int PI_WIN_WDOG    = 6;
  localparam int PI_RTC         = 7;
  localparam int PI_UTICK       = 8;
  localparam int PI_BROWNOUT    = 9;
  localparam int PI_ETHERNET    = 10;
  localparam int PI_OTHER       = 11;
  localparam int NUM_ANALOG_DEF = 4;
  localparam int NUM_IRQ_DEF    = 32;

  // Peripherals whose clock may stay on in deep-sleep
  localparam logic [NUM_PERIPH-1:0] DS_CLOCK_ALLOWED = (12'h001 << PI_USB0)
    | (12'h001 << PI_USB1) | (12'h001 << PI_MIC) | (12'h001 << PI_WIN_WDOG)
    | (12'h001 << PI_RTC) | (12'h001 << PI_UTICK) | (12'h001 << PI_BROWNOUT);

  // Mode selection codes; any other code means sleep
  localparam logic [1:0] MODE_SLEEP      = 2'h0;
  localparam logic [1:0] MODE_DEEP_SLEEP = 2'h1;
  localparam logic [1:0] MODE_DEEP_PD    = 2'h2;

  // Reset levels of clock enables and of gates
  localparam logic RST_ON  = 1'h1;
  localparam logic RST_OFF = 1'h0;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_DEEP_SLEEP,
    ST_DEEP_PD,
    ST_BOOT
  } pmc_state_t;
endpackage

// *** logic/pmc_wake_if.sv ***
// Wake source bundle between the controller and its wake detector
`timescale 1ns/1ps
interface pmc_wake_if #(
  parameter int NUM_ANALOG = 4
);
  logic                  irq_hit;
  logic                  pin_int;
  logic                  group_int;
  logic [11:0]           periph_wake;
  logic [11:0]           periph_keep;
  logic                  usart_wake;
  logic                  usart_wake_mode;
  logic                  spi_wake;
  logic                  spi_slave;
  logic                  i2c_wake;
  logic                  i2c_slave;
  logic [NUM_ANALOG-1:0] analog_wake;
  logic [NUM_ANALOG-1:0] analog_keep;
  logic                  rtc_alarm;
  logic                  reset_pin;
  logic                  sleep_wake;
  logic                  ds_wake;
  logic                  dpd_wake;

  modport src (output irq_hit, pin_int, group_int, periph_wake, periph_keep,
               usart_wake, usart_wake_mode, spi_wake, spi_slave, i2c_wake,
               i2c_slave, analog_wake, analog_keep, rtc_alarm, reset_pin,
               input sleep_wake, ds_wake, dpd_wake);
  modport det (input irq_hit, pin_int, group_int, periph_wake, periph_keep,
               usart_wake, usart_wake_mode, spi_wake, spi_slave, i2c_wake,
               i2c_slave, analog_wake, analog_keep, rtc_alarm, reset_pin,
               output sleep_wake, ds_wake, dpd_wake);
endinterface

// *** logic/pmc_sync.sv ***
// Two-stage synchroniser for asynchronous wake and pin levels
`timescale 1ns/1ps
module pmc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } pmc_sync_t;

  pmc_sync_t st_ff;
  pmc_sync_t nxt_st;

  // First stage feeds only the second stage
  always_comb
  begin
    nxt_st.meta   = d;
    nxt_st.stable = st_ff.meta;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign q = st_ff.stable;
endmodule

// *** logic/pmc_wake.sv ***
// Wake condition detector for each reduced-power mode
`timescale 1ns/1ps
module pmc_wake (
  pmc_wake_if.det w
);
  // Sleep ends on any enabled pending interrupt
  // clocked peripheral interrupts
  assign w.sleep_wake = w.irq_hit;

  // Deep-sleep wakes from sources left running
  always_comb
  begin
    w.ds_wake = w.irq_hit | w.pin_int | w.group_int | w.rtc_alarm;
    w.ds_wake = w.ds_wake | (|(w.periph_wake & w.periph_keep));
    w.ds_wake = w.ds_wake | (w.usart_wake & w.usart_wake_mode);
    w.ds_wake = w.ds_wake | (w.spi_wake & w.spi_slave) | (w.i2c_wake & w.i2c_slave);
    w.ds_wake = w.ds_wake | (|(w.analog_wake & w.analog_keep));
  end

  assign w.dpd_wake = w.reset_pin | w.rtc_alarm;
endmodule

// *** logic/pmc_power_mode_controller.sv ***
// Top of the power mode controller: mode sequencing and gate outputs
`timescale 1ns/1ps
module pmc_power_mode_controller
  import pmc_pkg::*;
#(
  parameter int NUM_ANALOG = NUM_ANALOG_DEF,
  parameter int NUM_IRQ    = NUM_IRQ_DEF
) (
  input  wire logic                  CLK,
  input  wire logic                  RESET,
  input  wire logic [1:0]            MODE_SELECT,
  input  wire logic                  WFI_REQ,
  input  wire logic [NUM_IRQ-1:0]    IRQ_PENDING,
  input  wire logic [NUM_IRQ-1:0]    IRQ_ENABLE,
  input  wire logic [NUM_PERIPH-1:0] PERIPH_CLK_ENABLE,
  input  wire logic [NUM_PERIPH-1:0] PERIPH_PWR_ENABLE,
  input  wire logic [NUM_PERIPH-1:0] PERIPH_DS_KEEP,
  input  wire logic [NUM_PERIPH-1:0] PERIPH_WAKE_REQ,
  input  wire logic                  PIN_INT_WAKE,
  input  wire logic                  PIN_INT_DS_KEEP,
  input  wire logic                  GROUP_INT_WAKE,
  input  wire logic                  GROUP_INT_DS_KEEP,
  input  wire logic                  USART_WAKE,
  input  wire logic                  USART_SYNC_SLAVE_MODE,
  input  wire logic                  USART_32K_CLOCK_MODE,
  input  wire logic                  SPI_WAKE,
  input  wire logic                  SPI_SLAVE_MODE,
  input  wire logic                  I2C_WAKE,
  input  wire logic                  I2C_SLAVE_MODE,
  input  wire logic [NUM_ANALOG-1:0] ANALOG_ENABLE,
  input  wire logic [NUM_ANALOG-1:0] ANALOG_DS_KEEP,
  input  wire logic [NUM_ANALOG-1:0] ANALOG_WAKE,
  input  wire logic                  FAST_OSC_ENABLE,
  input  wire logic                  FAST_OSC_DS_KEEP,
  input  wire logic                  PLL_ENABLE,
  input  wire logic                  WDOSC_ENABLE,
  input  wire logic                  WDOSC_DS_KEEP,
  input  wire logic                  RTC_OSC_ENABLE,
  input  wire logic                  FLASH_SLEEP_STANDBY,
  input  wire logic                  DMA_DS_ENABLE,
  input  wire logic                  EXTERNAL_RESET_PIN_LOW,
  input  wire logic                  RTC_ONE_SECOND_ALARM_FLAG,
  output logic                       CPU_CLK_EN,
  output logic                       MAIN_CLK_EN,
  output logic      [NUM_PERIPH-1:0] PERIPH_CLK_EN,
  output logic      [NUM_PERIPH-1:0] PERIPH_PWR_EN,
  output logic      [NUM_ANALOG-1:0] ANALOG_PWR_EN,
  output logic                       FAST_OSC_RUN,
  output logic                       PLL_RUN,
  output logic                       WDOSC_RUN,
  output logic                       RTC_OSC_RUN,
  output logic                       FLASH_STANDBY,
  output logic                       FLASH_PWR_EN,
  output logic                       DMA_CLK_EN,
  output logic                       RETAIN_STATE,
  output logic                       PIN_HOLD,
  output logic                       PIN_TRISTATE,
  output logic                       CORE_PWR_EN,
  output logic                       CHIP_RESET_REQ,
  output logic                       WAKE_EVENT,
  output logic      [2:0]            POWER_MODE
);
  // Width of the synchronised asynchronous group
  localparam int SYNC_W = NUM_PERIPH + NUM_ANALOG + 7;

  typedef struct packed {
    pmc_state_t            state;
    logic                  cpu_clk;
    logic                  main_clk;
    logic [NUM_PERIPH-1:0] periph_clk;
    logic [NUM_PERIPH-1:0] periph_pwr;
    logic [NUM_ANALOG-1:0] analog_pwr;
    logic                  fast_osc;
    logic                  pll;
    logic                  wdosc;
    logic                  rtc_osc;
    logic                  flash_standby;
    logic                  flash_pwr;
    logic                  dma_clk;
    logic                  retain;
    logic                  pin_hold;
    logic                  pin_hiz;
    logic                  core_pwr;
    logic                  reset_req;
    logic                  wake_event;
  } pmc_regs_t;

  pmc_regs_t             st_ff;
  pmc_regs_t             nxt_st;
  logic [SYNC_W-1:0]     async_in;
  logic [SYNC_W-1:0]     async_sync;
  logic [NUM_PERIPH-1:0] periph_wake_s;
  logic [NUM_ANALOG-1:0] analog_wake_s;
  logic                  pin_int_s;
  logic                  group_int_s;
  logic                  usart_wake_s;
  logic                  spi_wake_s;
  logic                  i2c_wake_s;
  logic                  reset_pin_s;
  logic                  alarm_s;
  logic [1:0]            target_mode;

  pmc_wake_if #(.NUM_ANALOG(NUM_ANALOG)) wake_bus ();

  // Pins and unclocked wake sources cross into the clock domain
  assign async_in = {PERIPH_WAKE_REQ, ANALOG_WAKE, PIN_INT_WAKE, GROUP_INT_WAKE,
                     USART_WAKE, SPI_WAKE, I2C_WAKE, EXTERNAL_RESET_PIN_LOW,
                     RTC_ONE_SECOND_ALARM_FLAG};

  pmc_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk   (CLK),
    .reset (RESET),
    .d     (async_in),
    .q     (async_sync)
  );

  assign {periph_wake_s, analog_wake_s, pin_int_s, group_int_s, usart_wake_s,
          spi_wake_s, i2c_wake_s, reset_pin_s, alarm_s} = async_sync;

  // Wake sources presented to the detector
  assign wake_bus.irq_hit         = |(IRQ_PENDING & IRQ_ENABLE);
  assign wake_bus.pin_int         = pin_int_s & PIN_INT_DS_KEEP;
  assign wake_bus.group_int       = group_int_s & GROUP_INT_DS_KEEP;
  assign wake_bus.periph_wake     = periph_wake_s;
  assign wake_bus.periph_keep     = PERIPH_DS_KEEP & PERIPH_PWR_ENABLE;
  assign wake_bus.usart_wake      = usart_wake_s;
  assign wake_bus.usart_wake_mode = USART_SYNC_SLAVE_MODE | USART_32K_CLOCK_MODE;
  assign wake_bus.spi_wake        = spi_wake_s;
  assign wake_bus.spi_slave       = SPI_SLAVE_MODE;
  assign wake_bus.i2c_wake        = i2c_wake_s;
  assign wake_bus.i2c_slave       = I2C_SLAVE_MODE;
  assign wake_bus.analog_wake     = analog_wake_s;
  assign wake_bus.analog_keep     = ANALOG_DS_KEEP;
  assign wake_bus.rtc_alarm       = alarm_s & st_ff.rtc_osc;
  assign wake_bus.reset_pin       = reset_pin_s;

  pmc_wake u_wake (
    .w (wake_bus.det)
  );

  always_comb
  begin
    unique case (MODE_SELECT)
      MODE_DEEP_SLEEP: target_mode = MODE_DEEP_SLEEP;
      MODE_DEEP_PD:    target_mode = MODE_DEEP_PD;
      default:         target_mode = MODE_SLEEP;
    endcase
  end

  // Mode sequencing, then gate values for the mode being entered
  always_comb
  begin
    nxt_st            = st_ff;
    nxt_st.reset_req  = 1'h0;
    nxt_st.wake_event = 1'h0;

    if (reset_pin_s)
    begin
      nxt_st.state     = ST_BOOT;
      nxt_st.reset_req = 1'h1;
      nxt_st.wake_event = (st_ff.state == ST_DEEP_PD);
    end
    else
    begin
      unique case (st_ff.state)
        ST_ACTIVE:
        begin
          if (WFI_REQ)
          begin
            unique case (target_mode)
              MODE_DEEP_SLEEP: nxt_st.state = ST_DEEP_SLEEP;
              MODE_DEEP_PD:    nxt_st.state = ST_DEEP_PD;
              default:         nxt_st.state = ST_SLEEP;
            endcase
          end
        end
        ST_SLEEP:
        begin
          if (wake_bus.sleep_wake)
          begin
            nxt_st.state      = ST_ACTIVE;
            nxt_st.wake_event = 1'h1;
          end
        end
        ST_DEEP_SLEEP:
        begin
          if (wake_bus.ds_wake)
          begin
            nxt_st.state      = ST_ACTIVE;
            nxt_st.wake_event = 1'h1;
          end
        end
        ST_DEEP_PD:
        begin
          if (wake_bus.dpd_wake)
          begin
            nxt_st.state      = ST_BOOT;
            nxt_st.reset_req  = 1'h1;
            nxt_st.wake_event = 1'h1;
          end
        end
        ST_BOOT:
        begin
          nxt_st.state = ST_ACTIVE;
        end
      endcase
    end

    // Defaults shared by the running modes
    nxt_st.core_pwr      = 1'h1;
    nxt_st.pin_hiz       = 1'h0;
    nxt_st.flash_pwr     = 1'h1;
    nxt_st.flash_standby = 1'h0;
    nxt_st.rtc_osc       = RTC_OSC_ENABLE;

    unique case (nxt_st.state)
      ST_ACTIVE,
      ST_BOOT:
      begin
        nxt_st.cpu_clk    = 1'h1;
        nxt_st.main_clk   = 1'h1;
        nxt_st.periph_clk = PERIPH_CLK_ENABLE;
        nxt_st.periph_pwr = PERIPH_PWR_ENABLE;
        nxt_st.analog_pwr = ANALOG_ENABLE;
        nxt_st.fast_osc   = FAST_OSC_ENABLE;
        nxt_st.pll        = PLL_ENABLE;
        nxt_st.wdosc      = WDOSC_ENABLE;
        nxt_st.dma_clk    = 1'h1;
        nxt_st.retain     = 1'h1;
        nxt_st.pin_hold   = 1'h0;
      end
      ST_SLEEP:
      begin
        nxt_st.cpu_clk       = 1'h0;
        nxt_st.main_clk      = 1'h1;
        nxt_st.periph_clk    = PERIPH_CLK_ENABLE;
        nxt_st.periph_pwr    = PERIPH_PWR_ENABLE;
        nxt_st.analog_pwr    = ANALOG_ENABLE;
        nxt_st.fast_osc      = FAST_OSC_ENABLE;
        nxt_st.pll           = PLL_ENABLE;
        nxt_st.wdosc         = WDOSC_ENABLE;
        nxt_st.flash_standby = FLASH_SLEEP_STANDBY;
        nxt_st.dma_clk       = 1'h1;
        nxt_st.retain        = 1'h1;
        nxt_st.pin_hold      = 1'h1;
      end
      ST_DEEP_SLEEP:
      begin
        nxt_st.cpu_clk       = 1'h0;
        nxt_st.main_clk      = 1'h0;
        nxt_st.periph_clk    = PERIPH_CLK_ENABLE & PERIPH_DS_KEEP & DS_CLOCK_ALLOWED;
        nxt_st.periph_pwr    = PERIPH_PWR_ENABLE;
        nxt_st.analog_pwr    = ANALOG_DS_KEEP;
        nxt_st.fast_osc      = FAST_OSC_DS_KEEP;
        nxt_st.wdosc         = WDOSC_DS_KEEP;
        nxt_st.pll           = 1'h0;
        nxt_st.flash_standby = 1'h1;
        nxt_st.dma_clk       = DMA_DS_ENABLE;
        nxt_st.retain        = 1'h1;
        nxt_st.pin_hold      = 1'h1;
      end
      ST_DEEP_PD:
      begin
        nxt_st.cpu_clk    = 1'h0;
        nxt_st.main_clk   = 1'h0;
        nxt_st.periph_clk = '0;
        nxt_st.periph_pwr = '0;
        nxt_st.analog_pwr = '0;
        nxt_st.fast_osc   = 1'h0;
        nxt_st.pll        = 1'h0;
        nxt_st.wdosc      = 1'h0;
        nxt_st.dma_clk    = 1'h0;
        nxt_st.core_pwr   = 1'h0;
        nxt_st.flash_pwr  = 1'h0;
        nxt_st.retain     = 1'h0;
        nxt_st.pin_hold   = 1'h0;
        nxt_st.pin_hiz    = 1'h1;
      end
    endcase
  end

  // State register with constant reset values
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      st_ff               <= '0;
      st_ff.state         <= ST_ACTIVE;
      st_ff.cpu_clk       <= RST_ON;
      st_ff.main_clk      <= RST_ON;
      st_ff.fast_osc      <= RST_ON;
      st_ff.flash_pwr     <= RST_ON;
      st_ff.dma_clk       <= RST_ON;
      st_ff.retain        <= RST_ON;
      st_ff.core_pwr      <= RST_ON;
      st_ff.rtc_osc       <= RST_OFF;
      st_ff.pin_hiz       <= RST_OFF;
    end
    else
      st_ff <= nxt_st;
  end

  // Outputs come straight from the state register
  assign CPU_CLK_EN     = st_ff.cpu_clk;
  assign MAIN_CLK_EN    = st_ff.main_clk;
  assign PERIPH_CLK_EN  = st_ff.periph_clk;
  assign PERIPH_PWR_EN  = st_ff.periph_pwr;
  assign ANALOG_PWR_EN  = st_ff.analog_pwr;
  assign FAST_OSC_RUN   = st_ff.fast_osc;
  assign PLL_RUN        = st_ff.pll;
  assign WDOSC_RUN      = st_ff.wdosc;
  assign RTC_OSC_RUN    = st_ff.rtc_osc;
  assign FLASH_STANDBY  = st_ff.flash_standby;
  assign FLASH_PWR_EN   = st_ff.flash_pwr;
  assign DMA_CLK_EN     = st_ff.dma_clk;
  assign RETAIN_STATE   = st_ff.retain;
  assign PIN_HOLD       = st_ff.pin_hold;
  assign PIN_TRISTATE   = st_ff.pin_hiz;
  assign CORE_PWR_EN    = st_ff.core_pwr;
  assign CHIP_RESET_REQ = st_ff.reset_req;
  assign WAKE_EVENT     = st_ff.wake_event;
  assign POWER_MODE     = st_ff.state;
endmodule

// *** testbench/pmc_checker.sv ***
// Port assertions for the power mode controller
`timescale 1ns/1ps
module pmc_checker
  import pmc_pkg::*;
#(
  parameter int NUM_IRQ = NUM_IRQ_DEF
) (
  input logic                  CLK,
  input logic                  RESET,
  input logic [1:0]            MODE_SELECT,
  input logic                  WFI_REQ,
  input logic [NUM_IRQ-1:0]    IRQ_PENDING,
  input logic [NUM_IRQ-1:0]    IRQ_ENABLE,
  input logic [NUM_PERIPH-1:0] PERIPH_CLK_ENABLE,
  input logic [NUM_PERIPH-1:0] PERIPH_PWR_ENABLE,
  input logic [NUM_PERIPH-1:0] PERIPH_DS_KEEP,
  input logic                  RTC_OSC_ENABLE,
  input logic                  EXTERNAL_RESET_PIN_LOW,
  input logic                  CPU_CLK_EN,
  input logic                  MAIN_CLK_EN,
  input logic [NUM_PERIPH-1:0] PERIPH_CLK_EN,
  input logic [NUM_PERIPH-1:0] PERIPH_PWR_EN,
  input logic                  PLL_RUN,
  input logic                  RTC_OSC_RUN,
  input logic                  FLASH_STANDBY,
  input logic                  FLASH_PWR_EN,
  input logic                  RETAIN_STATE,
  input logic                  PIN_HOLD,
  input logic                  PIN_TRISTATE,
  input logic                  CORE_PWR_EN,
  input logic                  CHIP_RESET_REQ,
  input logic                  WAKE_EVENT,
  input logic [2:0]            POWER_MODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  logic [NUM_PERIPH-1:0] ds_want;
  logic                  act;
  // Clocks allowed to run in deep-sleep, and a taken entry request
  assign ds_want = PERIPH_CLK_ENABLE & PERIPH_DS_KEEP & DS_CLOCK_ALLOWED;
  assign act = POWER_MODE == 3'h0 && WFI_REQ;
  // Boot step after leaving deep power-down
  sequence s_dpd_left;
    POWER_MODE == 3'h3 ##1 POWER_MODE != 3'h3;
  endsequence
  sequence s_boot;
    POWER_MODE == 3'h4 && CHIP_RESET_REQ && WAKE_EVENT && CORE_PWR_EN;
  endsequence
  sleep_entry_a:
  assert property (act && (MODE_SELECT == 2'h0 || MODE_SELECT == 2'h3) |=> POWER_MODE == 3'h1
    && !CPU_CLK_EN && MAIN_CLK_EN && PIN_HOLD && RETAIN_STATE) else $error("bad sleep entry");
  ds_entry_a:
  assert property (act && MODE_SELECT == 2'h1 |=> POWER_MODE == 3'h2 && !CPU_CLK_EN
    && !MAIN_CLK_EN && !PLL_RUN && FLASH_STANDBY && PIN_HOLD) else $error("bad deep entry");
  ds_gates_a:
  assert property (POWER_MODE == 3'h2 |-> PERIPH_CLK_EN == $past(ds_want))
    else $error("bad deep-sleep gates");
  active_gates_a:
  assert property (POWER_MODE == 3'h0 && $past(POWER_MODE) == 3'h0 && !$past(RESET)
    |-> PERIPH_CLK_EN == $past(PERIPH_CLK_ENABLE) && PERIPH_PWR_EN == $past(PERIPH_PWR_ENABLE))
    else $error("bad active gates");
  dpd_state_a:
  assert property (POWER_MODE == 3'h3 |-> !CORE_PWR_EN && PIN_TRISTATE && !FLASH_PWR_EN
    && !RETAIN_STATE) else $error("bad power-down state");
  dpd_rtc_a:
  assert property (POWER_MODE == 3'h3 && $past(POWER_MODE) == 3'h3
    |-> RTC_OSC_RUN == $past(RTC_OSC_ENABLE)) else $error("bad rtc oscillator");
  dpd_exit_a:
  assert property (s_dpd_left |-> s_boot) else $error("bad power-down exit");
  pin_reset_a:
  assert property (EXTERNAL_RESET_PIN_LOW [*3] |=> POWER_MODE == 3'h4 && CHIP_RESET_REQ)
    else $error("reset pin not taken");
  irq_wake_a:
  assert property (POWER_MODE == 3'h1 && |(IRQ_PENDING & IRQ_ENABLE) |=> POWER_MODE == 3'h0
    && WAKE_EVENT && CPU_CLK_EN) else $error("no wake from sleep");
endmodule

bind pmc_power_mode_controller pmc_checker #(.NUM_IRQ(NUM_IRQ)) i_chk (
  .CLK(CLK), .RESET(RESET), .MODE_SELECT(MODE_SELECT), .WFI_REQ(WFI_REQ),
  .IRQ_PENDING(IRQ_PENDING), .IRQ_ENABLE(IRQ_ENABLE), .PERIPH_CLK_ENABLE(PERIPH_CLK_ENABLE),
  .PERIPH_PWR_ENABLE(PERIPH_PWR_ENABLE), .PERIPH_DS_KEEP(PERIPH_DS_KEEP),
  .RTC_OSC_ENABLE(RTC_OSC_ENABLE), .EXTERNAL_RESET_PIN_LOW(EXTERNAL_RESET_PIN_LOW),
  .CPU_CLK_EN(CPU_CLK_EN), .MAIN_CLK_EN(MAIN_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
  .PERIPH_PWR_EN(PERIPH_PWR_EN), .PLL_RUN(PLL_RUN), .RTC_OSC_RUN(RTC_OSC_RUN),
  .FLASH_STANDBY(FLASH_STANDBY), .FLASH_PWR_EN(FLASH_PWR_EN), .RETAIN_STATE(RETAIN_STATE),
  .PIN_HOLD(PIN_HOLD), .PIN_TRISTATE(PIN_TRISTATE), .CORE_PWR_EN(CORE_PWR_EN),
  .CHIP_RESET_REQ(CHIP_RESET_REQ), .WAKE_EVENT(WAKE_EVENT), .POWER_MODE(POWER_MODE)
);

// *** testbench/pmc_far_model.sv ***
// Far-side model: interrupt line, wake sources, alarm and reset pin
`timescale 1ns/1ps
module pmc_far_model (
  input  logic       clk,
  input  logic       fire,
  input  logic [2:0] sel,
  input  logic [7:0] dly,
  input  logic       wake_seen,
  input  logic       reset_seen,
  output logic [7:0] src
);
  logic [7:0] cnt;
  logic [2:0] pick;
  logic       armed;
  initial
  begin
    src = 8'h00;
    armed = 1'b0;
  end
  // Raise the chosen source after a delay; all drop once the wake is seen
  always @(posedge clk)
  begin
    if (fire)
    begin
      armed <= 1'b1;
      cnt <= dly;
      pick <= sel;
    end
    else if (armed && cnt == 8'h00)
    begin
      armed <= 1'b0;
      src[pick] <= 1'b1;
    end
    else if (armed)
      cnt <= cnt - 8'h01;
    if (wake_seen)
      src <= 8'h00;
    if (reset_seen)
      src[7] <= 1'b0;
  end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
module tb;
  import pmc_pkg::*;
  logic        clk = 1'b0, rst, wfi, fire, osc_en, rtc_en, fosc_k, wd_k, dma_k, fl_k;
  logic        cpu, mainc, fosc, pll, wdo, rtc, fsb, fpw, dma, ret, hold, tri_s, core;
  logic        rreq, wake;
  logic [1:0]  mode;
  logic [2:0]  sel, pm;
  logic [7:0]  dly, src;
  logic [15:0] wk;
  logic [6:0]  g;
  logic [3:0]  an_en, an_k, an_p;
  logic [11:0] ck_en, pw_en, ds_k, p_ck, p_pw;
  logic [31:0] irq_en;
  logic [11:0] pat[2] = '{12'ha5c, 12'hfff};
  logic [1:0]  sm[2] = '{2'h0, 2'h3};
  int          srcs[6] = '{1, 2, 3, 4, 5, 3};
  int          gates[6] = '{1, 2, 3, 4, 5, 6};
  int          err_count, checked;
  pmc_power_mode_controller i_dut (
    .CLK(clk), .RESET(rst), .MODE_SELECT(mode), .WFI_REQ(wfi),
    .IRQ_PENDING({28'h0, src[0], 3'h0}), .IRQ_ENABLE(irq_en), .PERIPH_CLK_ENABLE(ck_en),
    .PERIPH_PWR_ENABLE(pw_en), .PERIPH_DS_KEEP(ds_k), .PERIPH_WAKE_REQ(wk[11:0]),
    .PIN_INT_WAKE(src[1]), .PIN_INT_DS_KEEP(g[1]), .GROUP_INT_WAKE(src[2]),
    .GROUP_INT_DS_KEEP(g[2]), .USART_WAKE(src[3]), .USART_SYNC_SLAVE_MODE(g[3]),
    .USART_32K_CLOCK_MODE(g[6]), .SPI_WAKE(src[4]), .SPI_SLAVE_MODE(g[4]),
    .I2C_WAKE(src[5]), .I2C_SLAVE_MODE(g[5]), .ANALOG_ENABLE(an_en), .ANALOG_DS_KEEP(an_k),
    .ANALOG_WAKE(wk[15:12]), .FAST_OSC_ENABLE(osc_en), .FAST_OSC_DS_KEEP(fosc_k),
    .PLL_ENABLE(osc_en),
    .WDOSC_ENABLE(osc_en), .WDOSC_DS_KEEP(wd_k), .RTC_OSC_ENABLE(rtc_en),
    .FLASH_SLEEP_STANDBY(fl_k), .DMA_DS_ENABLE(dma_k), .EXTERNAL_RESET_PIN_LOW(src[7]),
    .RTC_ONE_SECOND_ALARM_FLAG(src[6]), .CPU_CLK_EN(cpu), .MAIN_CLK_EN(mainc),
    .PERIPH_CLK_EN(p_ck), .PERIPH_PWR_EN(p_pw), .ANALOG_PWR_EN(an_p), .FAST_OSC_RUN(fosc),
    .PLL_RUN(pll), .WDOSC_RUN(wdo), .RTC_OSC_RUN(rtc), .FLASH_STANDBY(fsb),
    .FLASH_PWR_EN(fpw), .DMA_CLK_EN(dma), .RETAIN_STATE(ret), .PIN_HOLD(hold),
    .PIN_TRISTATE(tri_s), .CORE_PWR_EN(core), .CHIP_RESET_REQ(rreq), .WAKE_EVENT(wake),
    .POWER_MODE(pm)
  );
  pmc_far_model i_far (.clk(clk), .fire(fire), .sel(sel), .dly(dly), .wake_seen(wake),
    .reset_seen(rreq), .src(src));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Request entry into a mode for one cycle
  task automatic enter(input logic [1:0] m);
    mode = m;
    wfi = 1'b1;
    tick(1);
    wfi = 1'b0;
  endtask
  // Ask the far side to raise a source after a delay
  task automatic fire_src(input logic [2:0] s, input logic [7:0] d);
    sel = s;
    dly = d;
    fire = 1'b1;
    tick(1);
    fire = 1'b0;
  endtask
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (pm !== m && n < 20)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic rst_vals;
    chk({pm, cpu, mainc, fosc, fpw, dma, ret, core, rtc, tri_s, rreq, wake}, {3'h0, 11'h7f0});
    chk(p_ck | p_pw, 32'h0);
  endtask
  task automatic done_t(input string s);
    $display("test %s finished", s);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog against a hang
  initial
  begin
    repeat (3000) @(posedge clk);
    err_count++;
    report_and_stop;
  end
  // Test sequence
  initial
  begin
    {wfi, fire, sel, dly, g, mode, ck_en, pw_en, ds_k, an_k, fosc_k, wd_k, dma_k, wk} = '0;
    {rst, osc_en, rtc_en, fl_k, an_en, irq_en} = {4'hf, 4'hf, 32'h8};
    tick(12);
    rst_vals;
    rst = 1'b0;
    foreach (pat[i])
    begin
      ck_en = pat[i];
      pw_en = ~pat[i];
      tick(1);
      chk(p_ck, ck_en);
      chk(p_pw, pw_en);
    end
    pw_en = 12'hfff;
    done_t("gating");
    foreach (sm[i])
    begin
      irq_en = 32'h0;
      enter(sm[i]);
      chk({pm, cpu, mainc, hold, ret, dma, fsb}, {3'h1, 1'b0, 5'h1f});
      chk(p_ck, ck_en);
      fire_src(3'h0, 8'h01);
      tick(6);
      chk(pm, 32'h1);
      irq_en = 32'h8;
      tick(1);
      chk({pm, cpu, wake}, 32'h3);
      tick(1);
      chk(wake, 32'h0);
    end
    enter(2'h0);
    rst = 1'b1;
    tick(2);
    rst_vals;
    rst = 1'b0;
    done_t("sleep");
    for (int i = 0; i < 6; i++)
    begin
      fosc_k = i[0];
      wd_k = !i[0];
      dma_k = i[0];
      an_k = i[0] ? 4'h5 : 4'ha;
      ds_k = i[0] ? 12'h0f5 : 12'hf0a;
      enter(2'h1);
      chk({pm, cpu, mainc, pll, fsb}, {3'h2, 4'h1});
      chk(p_ck, ck_en & ds_k & DS_CLOCK_ALLOWED);
      chk({an_p, fosc, wdo, dma}, {an_k, fosc_k, wd_k, dma_k});
      chk({ret, hold}, 32'h3);
      fire_src(srcs[i][2:0], 8'h02);
      tick(8);
      chk(pm, 32'h2);
      g[gates[i]] = 1'b1;
      wait_mode(3'h0);
      chk(pm, 32'h0);
      g = 7'h00;
    end
    done_t("deep_sleep");
    // Kept peripheral and analog wake requests; unkept ones refused
    ds_k = 12'h001;
    an_k = 4'h2;
    wk = 16'h1002;
    enter(2'h1);
    tick(4);
    chk(pm, 32'h2);
    wk = 16'h0001;
    wait_mode(3'h0);
    chk(pm, 32'h0);
    {wk, ds_k} = {16'h2000, 12'h000};
    enter(2'h1);
    chk(pm, 32'h2);
    wait_mode(3'h0);
    chk(pm, 32'h0);
    wk = 16'h0000;
    done_t("ds_sources");
    enter(2'h2);
    chk({pm, core, tri_s, fpw, ret, rtc}, {3'h3, 5'h09});
    fire_src(3'h0, 8'h01);
    tick(8);
    chk(pm, 32'h3);
    fire_src(3'h6, 8'h03);
    wait_mode(3'h4);
    chk({pm, rreq, wake, core}, {3'h4, 3'h7});
    tick(1);
    chk({pm, rreq}, 32'h0);
    done_t("power_down");
    ds_k = 12'h000;
    tick(2);
    enter(2'h1);
    chk(pm, 32'h2);
    fire_src(3'h7, 8'h01);
    wait_mode(3'h4);
    chk({pm, rreq}, {3'h4, 1'b1});
    wait_mode(3'h0);
    chk(pm, 32'h0);
    done_t("reset_pin");
    report_and_stop;
  end
endmodule
